/* File: rtl/fdpi_pkg.sv */
// Package for the floppy drive pin interface: constants and carrier types
package fdpi_pkg;
    // Step pulse low time and gap between steps
    localparam int STEP_LOW_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int STEP_LOW_CYC = (STEP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_GAP_NS = 1000;
    localparam int STEP_GAP_CYC = (STEP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Write gate lead before first flux bit
    localparam int WGATE_LEAD_NS = 100;
    localparam int WGATE_LEAD_CYC = (WGATE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    // Media change status byte, read at host port 3F7H
    localparam logic [10:0] MEDIA_STAT_ADDR = 11'h3f7;
    localparam int MEDIA_STAT_BIT = 7;
    localparam logic [1:0] DENSITY_RST = 2'h0;

    // Seek request from the command engine
    typedef struct packed {
        logic start;
        logic outward;
        logic [7:0] tracks;
    } fdpi_seek_t;

    // Drive and media control from the command engine and configuration
    typedef struct packed {
        logic [1:0] driveSel;
        logic [1:0] motorOn;
        logic headSide;
        logic [1:0] densityCfg;
    } fdpi_drive_t;

    // Synchronised drive status
    typedef struct packed {
        logic trackZero;
        logic indexHole;
        logic writeProt;
        logic mediaChanged;
    } fdpi_status_t;

    typedef enum logic [1:0] {
        SK_IDLE = 2'b00,
        SK_LOW = 2'b01,
        SK_GAP = 2'b10
    } fdpi_seek_state_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_LEAD = 2'b01,
        WR_RUN = 2'b10
    } fdpi_wr_state_t;
endpackage : fdpi_pkg

/* File: rtl/fdpi_step.sv */
// Seek stepper: direction set first, then one low pulse per track
`timescale 1ns/1ps
module fdpi_step import fdpi_pkg::*; #(
    parameter int LOW_CYC = STEP_LOW_CYC,
    parameter int GAP_CYC = STEP_GAP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire fdpi_seek_t seekReq,
    output logic stepN,
    output logic outward,
    output logic busy
);
    fdpi_seek_state_t state_q, state_d;
    logic [7:0] left_q, left_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic stepN_q, stepN_d;
    logic dir_q, dir_d;

    always_comb begin
        state_d = state_q;
        left_d = left_q;
        cnt_d = cnt_q;
        stepN_d = 1'b1;
        dir_d = dir_q;
        unique case (state_q)
            SK_IDLE: begin
                if (seekReq.start && seekReq.tracks != 8'h00) begin
                    dir_d = seekReq.outward;
                    left_d = seekReq.tracks;
                    // Gap first so direction settles before the first pulse
                    cnt_d = CNT_W'(GAP_CYC - 1);
                    state_d = SK_GAP;
                end
            end
            SK_GAP: begin
                if (cnt_q == '0) begin
                    if (left_q == 8'h00) begin
                        state_d = SK_IDLE;
                    end else begin
                        stepN_d = 1'b0;
                        cnt_d = CNT_W'(LOW_CYC - 1);
                        left_d = left_q - 8'h01;
                        state_d = SK_LOW;
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            SK_LOW: begin
                if (cnt_q == '0) begin
                    cnt_d = CNT_W'(GAP_CYC - 1);
                    state_d = SK_GAP;
                end else begin
                    stepN_d = 1'b0;
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: state_d = SK_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SK_IDLE;
            left_q <= 8'h00;
            cnt_q <= '0;
            stepN_q <= 1'b1;
            dir_q <= 1'b0;
        end else begin
            state_q <= state_d;
            left_q <= left_d;
            cnt_q <= cnt_d;
            stepN_q <= stepN_d;
            dir_q <= dir_d;
        end
    end

    assign stepN = stepN_q;
    assign outward = dir_q;
    assign busy = (state_q != SK_IDLE);
endmodule : fdpi_step

/* File: rtl/fdpi_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fdpi_sync import fdpi_pkg::*; #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pinIn,
    output logic level,
    output logic fall
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic level_q;
    logic level_d;
    logic fall_q;
    logic fall_d;

    always_comb begin
        stage_d = {stage_q[1:0], pinIn};
        level_d = level_q;
        fall_d = 1'b0;
        // Stage 0 feeds only stage 1; decision on stages 1 and 2
        if (stage_q[1] == stage_q[2]) begin
            level_d = stage_q[2];
            fall_d = level_q & ~stage_q[2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_q <= {3{RST_VAL}};
            level_q <= RST_VAL;
            fall_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            level_q <= level_d;
            fall_q <= fall_d;
        end
    end

    assign level = level_q;
    assign fall = fall_q;
endmodule : fdpi_sync

/* File: rtl/fdpi_top.sv */
// Floppy drive pin interface: pin drivers, write path and status sensing
`timescale 1ns/1ps
module fdpi_top import fdpi_pkg::*; #(
    parameter int LEAD_CYC = WGATE_LEAD_CYC,
    parameter int LOW_CYC = STEP_LOW_CYC,
    parameter int GAP_CYC = STEP_GAP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chipReset,
    input wire fdpi_seek_t seekReq,
    input wire fdpi_drive_t driveCtl,
    input wire logic cfgWrite,
    input wire logic [1:0] cfgDensity,
    input wire logic writeStart,
    input wire logic writeStop,
    input wire logic writeFlux,
    input wire logic hostRead,
    input wire logic [10:0] hostAddr,
    input wire logic read_flux_in_n,
    input wire logic track_zero_in_n,
    input wire logic index_hole_in_n,
    input wire logic write_protect_in_n,
    input wire logic media_changed_in_n,
    output logic head_side_sel,
    output logic seek_direction,
    output logic step_pulse_n,
    output logic write_gate_out_n,
    output logic write_flux_out_n,
    output logic [1:0] drive_sel_n,
    output logic [1:0] drive_sel_oe,
    output logic [1:0] motor_on_n,
    output logic [1:0] motor_on_oe,
    output logic density_out_zero,
    output logic density_out_one,
    output logic readFluxPulse,
    output logic seekBusy,
    output logic writeRefused,
    output logic writing,
    output fdpi_status_t status,
    output logic hostReadValid,
    output logic [7:0] hostReadData
);
    // Internal reset: the chip reset request only; pin reset acts through rst_n
    logic intRst;
    assign intRst = chipReset;

    // Synchronised pin levels, idle high like the pull-ups
    logic readLvl;
    logic readFall;
    logic trkLvl;
    logic idxLvl;
    logic wpLvl;
    logic dchgLvl;

    fdpi_sync #(.RST_VAL(1'b1)) uRead (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(read_flux_in_n),
        .level(readLvl),
        .fall(readFall)
    );
    fdpi_sync #(.RST_VAL(1'b1)) uTrk (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(track_zero_in_n),
        .level(trkLvl),
        .fall()
    );
    fdpi_sync #(.RST_VAL(1'b1)) uIdx (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(index_hole_in_n),
        .level(idxLvl),
        .fall()
    );
    fdpi_sync #(.RST_VAL(1'b1)) uWp (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(write_protect_in_n),
        .level(wpLvl),
        .fall()
    );
    fdpi_sync #(.RST_VAL(1'b1)) uDchg (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(media_changed_in_n),
        .level(dchgLvl),
        .fall()
    );

    // Stepper runs from the pin reset only; chip reset blocks new seeks
    // A seek in flight finishes so the head never stops between tracks
    logic stepN;
    logic stepOut;
    logic stepBusy;
    fdpi_seek_t seekGated;
    always_comb begin
        seekGated = seekReq;
        seekGated.start = seekReq.start & ~intRst;
    end
    fdpi_step #(.LOW_CYC(LOW_CYC), .GAP_CYC(GAP_CYC)) uStep (
        .clk(clk),
        .rst_n(rst_n),
        .seekReq(seekGated),
        .stepN(stepN),
        .outward(stepOut),
        .busy(stepBusy)
    );

    // Configuration survives chip reset, cleared only by power-on reset
    logic [1:0] cfgDen_q;
    logic [1:0] cfgDen_d;
    always_comb begin
        cfgDen_d = cfgDen_q;
        if (cfgWrite) begin
            cfgDen_d = cfgDensity;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgDen_q <= DENSITY_RST;
        end else begin
            cfgDen_q <= cfgDen_d;
        end
    end

    // Write path
    fdpi_wr_state_t wr_q;
    fdpi_wr_state_t wr_d;
    logic [CNT_W-1:0] lead_q;
    logic [CNT_W-1:0] lead_d;
    logic wgate_q;
    logic wgate_d;
    logic wflux_q;
    logic wflux_d;
    logic refused_q;
    logic refused_d;

    always_comb begin
        wr_d = wr_q;
        lead_d = lead_q;
        wgate_d = wgate_q;
        wflux_d = 1'b1;
        refused_d = 1'b0;
        unique case (wr_q)
            WR_IDLE: begin
                wgate_d = 1'b1;
                if (writeStart) begin
                    if (!wpLvl) begin
                        refused_d = 1'b1;
                    end else begin
                        wgate_d = 1'b0;
                        lead_d = CNT_W'(LEAD_CYC - 1);
                        wr_d = WR_LEAD;
                    end
                end
            end
            WR_LEAD: begin
                // Flux held off until the head current has settled
                if (lead_q == '0) begin
                    wr_d = WR_RUN;
                end else begin
                    lead_d = lead_q - 1'b1;
                end
            end
            WR_RUN: begin
                wflux_d = ~writeFlux;
            end
            default: wr_d = WR_IDLE;
        endcase
        // Protect or stop ends any write at once
        if (wr_q != WR_IDLE && (writeStop || !wpLvl)) begin
            wr_d = WR_IDLE;
            wgate_d = 1'b1;
            wflux_d = 1'b1;
        end
        if (intRst) begin
            wr_d = WR_IDLE;
            wgate_d = 1'b1;
            wflux_d = 1'b1;
            refused_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= WR_IDLE;
            lead_q <= '0;
            wgate_q <= 1'b1;
            wflux_q <= 1'b1;
            refused_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            lead_q <= lead_d;
            wgate_q <= wgate_d;
            wflux_q <= wflux_d;
            refused_q <= refused_d;
        end
    end

    // Pin and status registers
    logic head_q;
    logic head_d;
    logic [1:0] ds_q;
    logic [1:0] ds_d;
    logic [1:0] mtr_q;
    logic [1:0] mtr_d;
    logic [1:0] den_q;
    logic [1:0] den_d;
    logic rdPulse_q;
    logic rdPulse_d;
    fdpi_status_t stat_q;
    fdpi_status_t stat_d;
    logic hrv_q;
    logic hrv_d;
    logic [7:0] hrd_q;
    logic [7:0] hrd_d;

    always_comb begin
        head_d = ~driveCtl.headSide;
        ds_d = ~driveCtl.driveSel;
        mtr_d = ~driveCtl.motorOn;
        den_d = cfgDen_q;
        rdPulse_d = readFall;
        stat_d.trackZero = ~trkLvl;
        stat_d.indexHole = ~idxLvl;
        stat_d.writeProt = ~wpLvl;
        stat_d.mediaChanged = ~dchgLvl;
        hrv_d = hostRead && hostAddr == MEDIA_STAT_ADDR;
        hrd_d = 8'h00;
        hrd_d[MEDIA_STAT_BIT] = ~dchgLvl;
        if (intRst) begin
            head_d = 1'b1;
            ds_d = 2'h3;
            mtr_d = 2'h3;
            rdPulse_d = 1'b0;
            hrv_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_q <= 1'b1;
            ds_q <= 2'h3;
            mtr_q <= 2'h3;
            den_q <= DENSITY_RST;
            rdPulse_q <= 1'b0;
            stat_q <= '0;
            hrv_q <= 1'b0;
            hrd_q <= 8'h00;
        end else begin
            head_q <= head_d;
            ds_q <= ds_d;
            mtr_q <= mtr_d;
            den_q <= den_d;
            rdPulse_q <= rdPulse_d;
            stat_q <= stat_d;
            hrv_q <= hrv_d;
            hrd_q <= hrd_d;
        end
    end

    assign head_side_sel = head_q;
    assign seek_direction = stepOut;
    assign step_pulse_n = stepN;
    assign write_gate_out_n = wgate_q;
    assign write_flux_out_n = wflux_q;
    assign drive_sel_n = 2'h0;
    assign drive_sel_oe = ~ds_q;
    assign motor_on_n = 2'h0;
    assign motor_on_oe = ~mtr_q;
    assign density_out_zero = den_q[0];
    assign density_out_one = den_q[1];
    assign readFluxPulse = rdPulse_q;
    assign seekBusy = stepBusy;
    assign writeRefused = refused_q;
    assign writing = ~wgate_q;
    assign status = stat_q;
    assign hostReadValid = hrv_q;
    assign hostReadData = hrd_q;
endmodule : fdpi_top

/* File: sim/fdpi_asserts.sv */
// Checker for the floppy pin interface ports
`timescale 1ns/1ps
module fdpi_chk import fdpi_pkg::*; #(
    parameter int LOW_CYC = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chipReset,
    input wire fdpi_seek_t seekReq,
    input wire fdpi_drive_t driveCtl,
    input wire logic writeStart,
    input wire logic writeFlux,
    input wire logic read_flux_in_n,
    input wire logic head_side_sel,
    input wire logic seek_direction,
    input wire logic step_pulse_n,
    input wire logic write_gate_out_n,
    input wire logic write_flux_out_n,
    input wire logic [1:0] drive_sel_oe,
    input wire logic [1:0] motor_on_oe,
    input wire logic density_out_zero,
    input wire logic readFluxPulse,
    input wire logic seekBusy,
    input wire logic writing,
    input wire fdpi_status_t status
);
    logic [7:0] lowCnt_q;
    logic [7:0] lowCnt_d;
    // Length of the current step low time
    always_comb begin
        lowCnt_d = step_pulse_n ? 8'h00 : lowCnt_q + 8'h01;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt_q <= 8'h00;
        end else begin
            lowCnt_q <= lowCnt_d;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_HEAD: assert property (!chipReset |=> head_side_sel == !$past(driveCtl.headSide))
        else $error("head side wrong");
    AST_DIR: assert property (seekReq.start && seekReq.tracks != 8'h00 && !seekBusy
        && !chipReset |=> seekBusy && seek_direction == $past(seekReq.outward))
        else $error("seek direction wrong");
    AST_HOLD: assert property (seekBusy && $past(seekBusy) |-> $stable(seek_direction))
        else $error("direction moved in seek");
    AST_STEP: assert property ($rose(step_pulse_n) |-> lowCnt_q == LOW_CYC && seekBusy)
        else $error("step pulse length wrong");
    AST_WGATE: assert property (writeStart && !writing && !status.writeProt && !chipReset
        |=> !write_gate_out_n)
        else $error("write gate not asserted");
    AST_WFLUX: assert property ($fell(write_flux_out_n) |-> $past(writeFlux) && $past(writing))
        else $error("write flux without request");
    AST_READ: assert property ($fell(read_flux_in_n) |-> ##[1:8] readFluxPulse)
        else $error("read flux edge lost");
    AST_PROT: assert property (status.writeProt |=> write_gate_out_n)
        else $error("write while protected");
    AST_DRV: assert property (!chipReset |=> drive_sel_oe == $past(driveCtl.driveSel)
        && motor_on_oe == $past(driveCtl.motorOn))
        else $error("select or motor wrong");
    AST_CHIP: assert property (chipReset |=> write_gate_out_n && drive_sel_oe == 2'h0
        && $stable(density_out_zero))
        else $error("chip reset effect wrong");
endmodule : fdpi_chk

bind fdpi_top fdpi_chk #(.LOW_CYC(LOW_CYC)) fdpi_chk_i (.clk, .rst_n, .chipReset, .seekReq,
    .driveCtl, .writeStart, .writeFlux, .read_flux_in_n, .head_side_sel, .seek_direction,
    .step_pulse_n, .write_gate_out_n, .write_flux_out_n, .drive_sel_oe, .motor_on_oe,
    .density_out_zero, .readFluxPulse, .seekBusy, .writing, .status);

/* File: sim/fdpi_drive_model.sv */
// Behavioural floppy drive behind the pin interface
`timescale 1ns/1ps
module fdpi_drive_model #(
    parameter int START_TRK = 3,
    parameter int FLUX_CYC = 8
) (
    input wire logic clk,
    input wire logic selN,
    input wire logic motorN,
    input wire logic step_pulse_n,
    input wire logic seek_direction,
    input wire logic write_gate_out_n,
    input wire logic write_flux_out_n,
    output logic read_flux_in_n,
    output logic track_zero_in_n,
    output logic index_hole_in_n,
    output int track,
    output int steps,
    output int written,
    output int emitted
);
    int phase = 0;
    logic spin = 1'b0;
    initial begin
        track = START_TRK;
        steps = 0;
        written = 0;
        emitted = 0;
    end
    // Head moves on the trailing edge; it cannot go past track zero
    always @(posedge step_pulse_n) begin
        if ($time > 0 && selN === 1'b0) begin
            steps++;
            track = seek_direction ? ((track > 0) ? track - 1 : 0) : track + 1;
        end
    end
    // Enable only changes between pulses, so no pulse is cut short
    always @(negedge clk) begin
        phase <= (phase + 1) % (FLUX_CYC * 6);
        if (phase % FLUX_CYC == 4) begin
            spin <= selN === 1'b0 && motorN === 1'b0 && write_gate_out_n === 1'b1;
        end
    end
    // Released lines sit at the pull-up level
    assign read_flux_in_n = !(spin && phase % FLUX_CYC < 3);
    assign index_hole_in_n = !(spin && phase < 2);
    assign track_zero_in_n = (selN === 1'b0) ? (track != 0) : 1'b1;
    always @(negedge read_flux_in_n) emitted++;
    always @(negedge write_flux_out_n) begin
        if (write_gate_out_n === 1'b0) begin
            written++;
        end
    end
endmodule : fdpi_drive_model

/* File: sim/fdpi_top_tb.sv */
// Self-checking bench for the floppy pin interface
`timescale 1ns/1ps
module fdpi_top_tb import fdpi_pkg::*;;
    logic clk = 0, rst_n = 0, chipReset = 0, cfgWrite = 0, writeStart = 0, writeStop = 0;
    logic writeFlux = 0, hostRead = 0, write_protect_in_n = 1, media_changed_in_n = 1;
    fdpi_seek_t seekReq = '0;
    fdpi_drive_t driveCtl = '0;
    logic [1:0] cfgDensity = 2'h0, den = 2'h0;
    logic [10:0] hostAddr = 11'h000;
    logic read_flux_in_n, track_zero_in_n, index_hole_in_n, head_side_sel, seek_direction;
    logic step_pulse_n, write_gate_out_n, write_flux_out_n, density_out_zero, density_out_one;
    logic readFluxPulse, seekBusy, writeRefused, writing, hostReadValid;
    logic [1:0] drive_sel_n, drive_sel_oe, motor_on_n, motor_on_oe;
    logic [7:0] hostReadData;
    logic [31:0] r, rng = 32'h0000100f;
    fdpi_status_t status;
    int mismatches = 0, compares = 0, track, steps, written, emitted, expTrk = 3, seen = 0, s0, e0;
    fdpi_top #(.LEAD_CYC(2), .LOW_CYC(2), .GAP_CYC(2)) fdpi_top_i (.clk, .rst_n, .chipReset,
        .seekReq, .driveCtl, .cfgWrite, .cfgDensity, .writeStart, .writeStop, .writeFlux,
        .hostRead, .hostAddr, .read_flux_in_n, .track_zero_in_n, .index_hole_in_n,
        .write_protect_in_n, .media_changed_in_n, .head_side_sel, .seek_direction, .step_pulse_n,
        .write_gate_out_n, .write_flux_out_n, .drive_sel_n, .drive_sel_oe, .motor_on_n,
        .motor_on_oe, .density_out_zero, .density_out_one, .readFluxPulse, .seekBusy,
        .writeRefused, .writing, .status, .hostReadValid, .hostReadData);
    fdpi_drive_model fdpi_drive_model_i (.clk, .selN(drive_sel_oe[0] ? drive_sel_n[0] : 1'b1),
        .motorN(motor_on_oe[0] ? motor_on_n[0] : 1'b1), .step_pulse_n, .seek_direction,
        .write_gate_out_n, .write_flux_out_n, .read_flux_in_n, .track_zero_in_n,
        .index_hole_in_n, .track, .steps, .written, .emitted);
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (readFluxPulse === 1'b1) seen++;
    end
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkCnt(input int got, input int exp);
        chk(got, exp);
    endtask : chkCnt
    task automatic seek(input logic out, input logic [7:0] n);
        s0 = steps;
        @(posedge clk);
        seekReq <= '{1'b1, out, n};
        @(posedge clk);
        seekReq <= '{1'b1, !out, 8'h07};
        #1 chk(seek_direction, out);
        @(posedge clk);
        seekReq <= '0;
        for (int i = 0; i < 400 && seekBusy !== 1'b0; i++) @(posedge clk);
        if (seekBusy !== 1'b0) begin
            mismatches++;
            final_report();
        end
        expTrk = out ? ((expTrk > n) ? expTrk - n : 0) : expTrk + n;
        chkCnt(steps - s0, n);
        chkCnt(track, expTrk);
    endtask : seek
    task automatic wr(input logic prot, input int nf);
        s0 = written;
        @(posedge clk);
        writeStart <= 1'b1;
        @(posedge clk);
        writeStart <= 1'b0;
        writeFlux <= 1'b1;
        #1 chk({write_gate_out_n, writeRefused}, {prot, prot});
        @(posedge clk);
        writeFlux <= 1'b0;
        repeat (nf) begin
            @(posedge clk);
            writeFlux <= 1'b1;
            @(posedge clk);
            writeFlux <= 1'b0;
        end
        @(posedge clk);
        writeStop <= 1'b1;
        @(posedge clk);
        writeStop <= 1'b0;
        repeat (4) @(posedge clk);
        chkCnt(written - s0, prot ? 0 : nf);
    endtask : wr
    task automatic rd(input logic [10:0] a, input logic chg);
        media_changed_in_n <= !chg;
        repeat (8) @(posedge clk);
        hostAddr <= a;
        hostRead <= 1'b1;
        @(posedge clk);
        hostRead <= 1'b0;
        #1 chk(hostReadValid ? {1'b1, hostReadData} : 9'h000, (a == MEDIA_STAT_ADDR) ? {2'b11, 7'h00} & {1'b1, chg, 7'h00} : 9'h000);
    endtask : rd
    initial begin
        repeat (3) @(posedge clk);
        #1 chk({step_pulse_n, write_gate_out_n, write_flux_out_n, head_side_sel}, 4'hf);
        chk({drive_sel_oe, motor_on_oe, density_out_one, density_out_zero}, 6'h00);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (24) begin
            r = xs();
            @(posedge clk);
            driveCtl <= r[6:0];
            cfgDensity <= r[8:7];
            cfgWrite <= r[9];
            @(posedge clk);
            cfgWrite <= 1'b0;
            den = r[9] ? r[8:7] : den;
            #1 chk({head_side_sel, drive_sel_oe, motor_on_oe}, {!r[2], r[6:3]});
            chk({drive_sel_n, motor_on_n}, 4'h0);
            // Density pins lag the config register by one stage
            @(posedge clk);
            #1 chk({density_out_one, density_out_zero}, den);
        end
        // Drive 0 selected, motor on
        driveCtl <= 7'h28;
        repeat (6) @(posedge clk);
        seek(1'b0, 8'h02);
        seek(1'b1, 8'h01);
        seek(1'b1, 8'h04);
        seekReq <= '{1'b1, 1'b0, 8'h00};
        @(posedge clk);
        seekReq <= '0;
        repeat (6) @(posedge clk);
        chk({seekBusy, status.trackZero}, 2'b01);
        driveCtl <= 7'h20;
        repeat (30) @(posedge clk);
        e0 = emitted;
        s0 = seen;
        driveCtl <= 7'h28;
        repeat (300) @(posedge clk);
        driveCtl <= 7'h20;
        repeat (30) @(posedge clk);
        chkCnt(seen - s0, emitted - e0);
        wr(1'b0, 5);
        write_protect_in_n <= 1'b0;
        repeat (6) @(posedge clk);
        wr(1'b1, 3);
        write_protect_in_n <= 1'b1;
        repeat (6) @(posedge clk);
        writeStart <= 1'b1;
        @(posedge clk);
        writeStart <= 1'b0;
        repeat (3) @(posedge clk);
        chipReset <= 1'b1;
        @(posedge clk);
        chipReset <= 1'b0;
        #1 chk({write_gate_out_n, drive_sel_oe, density_out_one, density_out_zero}, {3'b100, den});
        rd(MEDIA_STAT_ADDR, 1'b1);
        rd(MEDIA_STAT_ADDR, 1'b0);
        rd(11'h3f6, 1'b1);
        final_report();
    end
endmodule : fdpi_top_tb
